// File: hdl/fe_config_regs.sv
// Front-end and synthesizer calibration configuration register bank
//
// Notes on behaviour
// - Power index points into eight-entry power table.
// - Keyed one uses index entry, zero entry zero.
// - Step entries zero to index for ramps.
// - Pump calibration stage skipped when enable zero.
// - Core select bit one picks high VCO.
// - Pump result low nibble, current exponential scale.
// - VCO result five bits, writes override it.
// - Host restores saved results, device uses them.
// - Receive bias driven from four two-bit fields.
`timescale 1ns/1ps
`default_nettype none
`include "fe_map.svh"

module fe_config_regs (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    // Register port from the serial interface decoder
    input  wire fe_pkg::reg_req_t    reg_req_i,
    output logic      [7:0]          reg_rdata_o,
    output logic                     reg_rvalid_o,
    // Calibration engine results
    input  wire fe_pkg::cal_result_t cal_result_i,
    // Transmit control and power table contents
    input  wire fe_pkg::tx_ctrl_t    tx_ctrl_i,
    input  wire fe_pkg::power_table_t power_level_table_i,
    // Front-end controls
    output fe_pkg::rx_bias_t         rx_bias_o,
    output logic      [1:0]          tx_lo_buffer_current_o,
    output logic      [7:0]          pa_setting_o,
    output logic      [2:0]          pa_entry_o,
    // Synthesizer controls
    output logic                     pump_cal_stage_enable_o,
    output logic      [1:0]          pump_cal_config_o,
    output logic      [3:0]          pump_current_code_o,
    output logic      [11:0]         pump_current_q8_o,
    output logic                     vco_core_high_select_o,
    output logic      [4:0]          vco_current_code_o
);
    import fe_pkg::*;

    // Stored register images; unused bits are held at zero
    logic [7:0] rx_bias_r,  rx_bias_nxt;    // Receive bias fields
    logic [7:0] tx_cfg_r,   tx_cfg_nxt;     // Transmit LO current and power index
    logic [7:0] pump_cal_r, pump_cal_nxt;   // Pump config, stage enable, result
    logic [7:0] vco_cal_r,  vco_cal_nxt;    // Core select and VCO result

    // Read path
    logic [7:0] rdata_r,  rdata_nxt;        // Registered read data
    logic       rvalid_r, rvalid_nxt;       // One-cycle read answer strobe

    // Derived outputs, registered, and their combinational fractional step
    logic [7:0]  pa_setting_r, pa_setting_nxt;   // Selected table entry value
    logic [11:0] pump_q8_r,    pump_q8_nxt;      // Relative pump current
    logic [11:0] frac_q8;                        // Fractional 2^(k/4) step

    // Ramp step divider
    logic [`FE_RAMP_CNT_W-1:0] div_r, div_nxt;   // Cycle counter
    logic                      step_en;          // One-cycle step pulse
    logic [2:0]                ramp_entry;       // Pointer from the sequencer

    // Write strobes by address
    logic wr_rx;
    logic wr_tx;
    logic wr_pc;
    logic wr_vc;

    // Address decode of a write
    always_comb begin
        wr_rx = reg_req_i.wr && (reg_req_i.addr == `FE_OFS_RX_BIAS);
        wr_tx = reg_req_i.wr && (reg_req_i.addr == `FE_OFS_TX_CONFIG);
        wr_pc = reg_req_i.wr && (reg_req_i.addr == `FE_OFS_PUMP_CAL);
        wr_vc = reg_req_i.wr && (reg_req_i.addr == `FE_OFS_VCO_CAL);
    end

    // Register next values; writes pass through the writable mask
    always_comb begin
        rx_bias_nxt  = rx_bias_r;
        tx_cfg_nxt   = tx_cfg_r;
        pump_cal_nxt = pump_cal_r;
        vco_cal_nxt  = vco_cal_r;
        if (wr_rx) begin
            rx_bias_nxt = reg_req_i.wdata & `FE_WMASK_RX_BIAS;
        end
        if (wr_tx) begin
            tx_cfg_nxt = reg_req_i.wdata & `FE_WMASK_TX_CONFIG;
        end
        if (wr_pc) begin
            // Host may restore a saved result here before a hop
            pump_cal_nxt = reg_req_i.wdata & `FE_WMASK_PUMP_CAL;
        end
        if (wr_vc) begin
            // A written VCO value overrides the calibrated one
            vco_cal_nxt = reg_req_i.wdata & `FE_WMASK_VCO_CAL;
        end
        // Calibration results land after any host write in the same cycle,
        // so a freshly measured value is never lost to a racing write
        if (cal_result_i.pump_valid) begin
            pump_cal_nxt[`FE_PC_RES_MSB:`FE_PC_RES_LSB] = cal_result_i.pump_code;
        end
        if (cal_result_i.vco_valid) begin
            vco_cal_nxt[`FE_VC_RES_MSB:`FE_VC_RES_LSB] = cal_result_i.vco_code;
        end
    end

    // Read mux; an unmapped address answers zero
    always_comb begin
        rvalid_nxt = reg_req_i.rd;
        rdata_nxt  = rdata_r;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `FE_OFS_RX_BIAS:   rdata_nxt = rx_bias_r;
                `FE_OFS_TX_CONFIG: rdata_nxt = tx_cfg_r & `FE_WMASK_TX_CONFIG;
                `FE_OFS_PUMP_CAL:  rdata_nxt = pump_cal_r;
                `FE_OFS_VCO_CAL:   rdata_nxt = vco_cal_r & `FE_WMASK_VCO_CAL;
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // Ramp step divider; a slow step keeps the PA spectrum clean during ramps
    always_comb begin
        if (div_r == `FE_RAMP_CNT_W'(`FE_RAMP_STEP_CYC - 1)) begin
            div_nxt = '0;
            step_en = 1'b1;
        end else begin
            div_nxt = div_r + `FE_RAMP_CNT_W'(1);
            step_en = 1'b0;
        end
    end

    // Fractional part of the exponential pump current
    always_comb begin
        case (pump_cal_r[`FE_PC_FRAC_MSB:`FE_PC_FRAC_LSB])
            2'h0:    frac_q8 = `FE_FRAC_Q8_0;
            2'h1:    frac_q8 = `FE_FRAC_Q8_1;
            2'h2:    frac_q8 = `FE_FRAC_Q8_2;
            default: frac_q8 = `FE_FRAC_Q8_3;
        endcase
    end

    // Derived outputs: pump current 2^(code/4) in Q8 and table lookup
    always_comb begin
        pump_q8_nxt    = frac_q8 << pump_cal_r[`FE_PC_EXP_MSB:`FE_PC_EXP_LSB];
        // The pointer walks 0..index; entry value comes from the table
        pa_setting_nxt = power_level_table_i[ramp_entry];
    end

    // Ramp sequencer walks table entries toward the power index
    fe_power_ramp u_ramp (
        .clk_i               (clk_i),
        .sys_rst_i           (sys_rst_i),
        .step_en_i           (step_en),
        .tx_ctrl_i           (tx_ctrl_i),
        .power_table_index_i (tx_cfg_r[`FE_TX_PIDX_MSB:`FE_TX_PIDX_LSB]),
        .entry_o             (ramp_entry)
    );

    // Register every state group on the single clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_bias_r    <= `FE_RST_RX_BIAS;
            tx_cfg_r     <= `FE_RST_TX_CONFIG;
            pump_cal_r   <= `FE_RST_PUMP_CAL;
            vco_cal_r    <= `FE_RST_VCO_CAL;
            rdata_r      <= 8'h00;
            rvalid_r     <= 1'b0;
            pa_setting_r <= 8'h00;
            pump_q8_r    <= `FE_FRAC_Q8_0;
            div_r        <= '0;
        end else begin
            rx_bias_r    <= rx_bias_nxt;
            tx_cfg_r     <= tx_cfg_nxt;
            pump_cal_r   <= pump_cal_nxt;
            vco_cal_r    <= vco_cal_nxt;
            rdata_r      <= rdata_nxt;
            rvalid_r     <= rvalid_nxt;
            pa_setting_r <= pa_setting_nxt;
            pump_q8_r    <= pump_q8_nxt;
            div_r        <= div_nxt;
        end
    end

    // Register read answer
    assign reg_rdata_o  = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    // Receive bias fields straight from the stored register
    // One assignment for the whole struct; per-field assigns would be
    // several continuous drivers on one packed variable
    assign rx_bias_o = {rx_bias_r[`FE_RX_AMP_MSB:`FE_RX_AMP_LSB],
                        rx_bias_r[`FE_RX_AMPMIX_MSB:`FE_RX_AMPMIX_LSB],
                        rx_bias_r[`FE_RX_LO_MSB:`FE_RX_LO_LSB],
                        rx_bias_r[`FE_RX_MIX_MSB:`FE_RX_MIX_LSB]};

    // Transmit front-end controls
    assign tx_lo_buffer_current_o = tx_cfg_r[`FE_TX_LO_MSB:`FE_TX_LO_LSB];
    assign pa_setting_o           = pa_setting_r;
    assign pa_entry_o             = ramp_entry;

    // Any nonzero enable value runs the pump stage; zero skips it
    assign pump_cal_stage_enable_o = |pump_cal_r[`FE_PC_EN_MSB:`FE_PC_EN_LSB];
    // Config bits are only passed on; loading them is the host's duty
    assign pump_cal_config_o       = pump_cal_r[`FE_PC_CFG_MSB:`FE_PC_CFG_LSB];
    assign pump_current_code_o     = pump_cal_r[`FE_PC_RES_MSB:`FE_PC_RES_LSB];
    assign pump_current_q8_o       = pump_q8_r;

    // VCO core choice and current code
    assign vco_core_high_select_o  = vco_cal_r[`FE_VC_CORE_BIT];
    assign vco_current_code_o      = vco_cal_r[`FE_VC_RES_MSB:`FE_VC_RES_LSB];

endmodule
`default_nettype wire

// File: hdl/fe_power_ramp.sv
// Power ramp sequencer: steps the power table pointer toward its target
`timescale 1ns/1ps
`default_nettype none
`include "fe_map.svh"

module fe_power_ramp (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             step_en_i,       // One-cycle pulse per ramp step
    input  wire fe_pkg::tx_ctrl_t tx_ctrl_i,       // Transmit state, same clock
    input  wire logic [2:0]       power_table_index_i,
    output logic      [2:0]       entry_o          // Table entry in use now
);
    import fe_pkg::*;

    typedef enum logic [1:0] {RAMP_IDLE, RAMP_MOVE, RAMP_HOLD} ramp_state_t;

    ramp_state_t state_r, state_nxt;   // Sequencer state
    logic [2:0]  entry_r, entry_nxt;   // Current table pointer
    logic [2:0]  target;               // Where the pointer is heading

    // Target: power index for a one bit or plain carrier, entry zero otherwise
    always_comb begin
        if (!tx_ctrl_i.tx_active) begin
            target = 3'h0;                                  // Ramp-down at end
        end else if (tx_ctrl_i.keyed_mode && !tx_ctrl_i.tx_bit) begin
            target = 3'h0;                                  // Keyed zero bit
        end else begin
            target = power_table_index_i;                   // One bit or carrier
        end
    end

    // Next pointer: one entry per step, never a jump, so shaping is gradual
    always_comb begin
        state_nxt = state_r;
        entry_nxt = entry_r;
        case (state_r)
            RAMP_IDLE: begin
                if (tx_ctrl_i.tx_active) begin
                    state_nxt = RAMP_MOVE;                  // Ramp-up from zero
                end
            end
            RAMP_MOVE, RAMP_HOLD: begin
                if (entry_r == target) begin
                    state_nxt = (tx_ctrl_i.tx_active) ? RAMP_HOLD : RAMP_IDLE;
                end else if (step_en_i) begin
                    state_nxt = RAMP_MOVE;
                    if (entry_r < target) begin
                        entry_nxt = entry_r + 3'h1;         // Step up
                    end else begin
                        entry_nxt = entry_r - 3'h1;         // Step down
                    end
                end
            end
            default: begin
                state_nxt = RAMP_IDLE;
                entry_nxt = 3'h0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= RAMP_IDLE;
            entry_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            entry_r <= entry_nxt;
        end
    end

    assign entry_o = entry_r;

endmodule
`default_nettype wire

// File: include/fe_map.svh
// Register offsets, field positions, reset values and timing counts for the front-end config bank
`ifndef FE_MAP_SVH
`define FE_MAP_SVH

// Register offsets on the serial register port
`define FE_ADDR_W              6
`define FE_OFS_RX_BIAS         6'h21
`define FE_OFS_TX_CONFIG       6'h22
`define FE_OFS_PUMP_CAL        6'h23
`define FE_OFS_VCO_CAL         6'h24

// Reset values
`define FE_RST_RX_BIAS         8'h56
`define FE_RST_TX_CONFIG       8'h10
`define FE_RST_PUMP_CAL        8'hA9
`define FE_RST_VCO_CAL         8'h0A

// Writable bit masks; zero bits are unused, read as zero
`define FE_WMASK_RX_BIAS       8'hFF
`define FE_WMASK_TX_CONFIG     8'h37
`define FE_WMASK_PUMP_CAL      8'hFF
`define FE_WMASK_VCO_CAL       8'h3F

// Field positions
`define FE_RX_AMP_MSB          7
`define FE_RX_AMP_LSB          6
`define FE_RX_AMPMIX_MSB       5
`define FE_RX_AMPMIX_LSB       4
`define FE_RX_LO_MSB           3
`define FE_RX_LO_LSB           2
`define FE_RX_MIX_MSB          1
`define FE_RX_MIX_LSB          0
`define FE_TX_LO_MSB           5
`define FE_TX_LO_LSB           4
`define FE_TX_PIDX_MSB         2
`define FE_TX_PIDX_LSB         0
`define FE_PC_CFG_MSB          7
`define FE_PC_CFG_LSB          6
`define FE_PC_EN_MSB           5
`define FE_PC_EN_LSB           4
`define FE_PC_RES_MSB          3
`define FE_PC_RES_LSB          0
`define FE_PC_EXP_MSB          3
`define FE_PC_EXP_LSB          2
`define FE_PC_FRAC_MSB         1
`define FE_PC_FRAC_LSB         0
`define FE_VC_CORE_BIT         5
`define FE_VC_RES_MSB          4
`define FE_VC_RES_LSB          0

// Pump current fractional steps 2^(k/4) in Q8, k = 0..3
`define FE_FRAC_Q8_0           12'h100
`define FE_FRAC_Q8_1           12'h130
`define FE_FRAC_Q8_2           12'h16A
`define FE_FRAC_Q8_3           12'h1AF

// Power ramp: one table step per interval
`define FE_CLK_MHZ             125
`define FE_RAMP_STEP_NS        64
`define FE_RAMP_STEP_CYC       ((`FE_RAMP_STEP_NS * `FE_CLK_MHZ + 999) / 1000)
`define FE_RAMP_CNT_W          8

`endif

// File: include/fe_pkg.sv
// Types shared by the front-end config bank and its power ramp sequencer
package fe_pkg;

    // Register port request from the serial interface decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Receive front-end bias fields
    typedef struct packed {
        logic [1:0] amp_current;
        logic [1:0] amp_to_mixer_current;
        logic [1:0] lo_buffer_current;
        logic [1:0] mixer_current;
    } rx_bias_t;

    // Result delivered by the synthesizer calibration engine
    typedef struct packed {
        logic       pump_valid;
        logic [3:0] pump_code;
        logic       vco_valid;
        logic [4:0] vco_code;
    } cal_result_t;

    // Transmit power stepping request
    typedef struct packed {
        logic       tx_active;
        logic       keyed_mode;
        logic       tx_bit;
    } tx_ctrl_t;

    // Power level table: eight entries of eight bits
    typedef logic [7:0][7:0] power_table_t;

endpackage

// File: verification/fe_config_regs_asserts.sv
// Concurrent checks on the front-end configuration bank ports
`timescale 1ns/1ps
`default_nettype none
`include "fe_map.svh"
module fe_config_regs_asserts (
    input wire logic                 clk_i,
    input wire logic                 sys_rst_i,
    input wire fe_pkg::reg_req_t     reg_req_i,
    input wire logic [7:0]           reg_rdata_o,
    input wire logic                 reg_rvalid_o,
    input wire fe_pkg::cal_result_t  cal_result_i,
    input wire fe_pkg::tx_ctrl_t     tx_ctrl_i,
    input wire fe_pkg::power_table_t power_level_table_i,
    input wire fe_pkg::rx_bias_t     rx_bias_o,
    input wire logic [7:0]           pa_setting_o,
    input wire logic [2:0]           pa_entry_o,
    input wire logic                 pump_cal_stage_enable_o,
    input wire logic [3:0]           pump_current_code_o,
    input wire logic [11:0]          pump_current_q8_o,
    input wire logic                 vco_core_high_select_o,
    input wire logic [4:0]           vco_current_code_o
);
    import fe_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic        seen_r;      // Low for the first edge after reset, guards $past
    logic [7:0]  set_r;       // Table entry expected on the power setting
    logic [11:0] q8_r;        // Expected pump current scale
    logic [7:0]  zero_cnt_r;  // Cycles the ramp target has been zero
    // Readable bits of each place; unmapped places read all zero
    function automatic logic [7:0] rmask(input logic [5:0] a);
        case (a)
            `FE_OFS_RX_BIAS:   return `FE_WMASK_RX_BIAS;
            `FE_OFS_TX_CONFIG: return `FE_WMASK_TX_CONFIG;
            `FE_OFS_PUMP_CAL:  return `FE_WMASK_PUMP_CAL;
            `FE_OFS_VCO_CAL:   return `FE_WMASK_VCO_CAL;
            default:           return 8'h00;
        endcase
    endfunction
    // Quarter-octave steps of the pump current
    function automatic logic [11:0] frac(input logic [1:0] k);
        case (k)
            2'h0:    return `FE_FRAC_Q8_0;
            2'h1:    return `FE_FRAC_Q8_1;
            2'h2:    return `FE_FRAC_Q8_2;
            default: return `FE_FRAC_Q8_3;
        endcase
    endfunction
    // Reference models one cycle behind; the counter saturates so it never wraps to zero
    always_ff @(posedge clk_i) begin
        seen_r <= !sys_rst_i;
        set_r  <= power_level_table_i[pa_entry_o];
        q8_r   <= frac(pump_current_code_o[1:0]) << pump_current_code_o[3:2];
        if (sys_rst_i || (tx_ctrl_i.tx_active && !(tx_ctrl_i.keyed_mode && !tx_ctrl_i.tx_bit))) begin
            zero_cnt_r <= 8'h00;
        end else if (zero_cnt_r != 8'hFF) begin
            zero_cnt_r <= zero_cnt_r + 8'h01;
        end
    end
    sequence rd_issue;
        reg_req_i.rd;
    endsequence
    sequence wr_at(logic [5:0] a);
        reg_req_i.wr && reg_req_i.addr == a;
    endsequence
    chk_read_answer: assert property (rd_issue |=> reg_rvalid_o)
        else $error("read not answered after one cycle");
    chk_unused_zero: assert property (seen_r && reg_rvalid_o
        |-> (reg_rdata_o & ~rmask($past(reg_req_i.addr))) == 8'h00) else $error("unused bits read set");
    chk_rx_bias_fields: assert property (wr_at(`FE_OFS_RX_BIAS)
        |=> rx_bias_o == $past(reg_req_i.wdata)) else $error("receive bias not from register");
    chk_pump_skip: assert property (wr_at(`FE_OFS_PUMP_CAL)
        |=> pump_cal_stage_enable_o == (|$past(reg_req_i.wdata[5:4]))) else $error("pump stage enable wrong");
    chk_vco_core: assert property (wr_at(`FE_OFS_VCO_CAL)
        |=> vco_core_high_select_o == $past(reg_req_i.wdata[5])) else $error("core select wrong");
    chk_vco_override: assert property (wr_at(`FE_OFS_VCO_CAL) ##0 !cal_result_i.vco_valid
        |=> vco_current_code_o == $past(reg_req_i.wdata[4:0])) else $error("override not taken");
    chk_vco_capture: assert property (cal_result_i.vco_valid
        |=> vco_current_code_o == $past(cal_result_i.vco_code)) else $error("vco result not stored");
    chk_pump_capture: assert property (cal_result_i.pump_valid
        |=> pump_current_code_o == $past(cal_result_i.pump_code)) else $error("pump result not stored");
    chk_pump_scale: assert property (seen_r |-> pump_current_q8_o == q8_r)
        else $error("pump current scale wrong");
    chk_pa_lookup: assert property (seen_r |-> pa_setting_o == set_r)
        else $error("power setting not from table entry");
    chk_ramp_step: assert property (seen_r && !$stable(pa_entry_o)
        |-> {1'b0, pa_entry_o} == {1'b0, $past(pa_entry_o)} + 4'h1
            || {1'b0, $past(pa_entry_o)} == {1'b0, pa_entry_o} + 4'h1) else $error("ramp skipped an entry");
    chk_ramp_zero: assert property (zero_cnt_r >= 8'h50 |-> pa_entry_o == 3'h0)
        else $error("entry not back at zero");
endmodule
bind fe_config_regs fe_config_regs_asserts u_chk (.clk_i, .sys_rst_i, .reg_req_i, .reg_rdata_o,
    .reg_rvalid_o, .cal_result_i, .tx_ctrl_i, .power_level_table_i, .rx_bias_o, .pa_setting_o,
    .pa_entry_o, .pump_cal_stage_enable_o, .pump_current_code_o, .pump_current_q8_o,
    .vco_core_high_select_o, .vco_current_code_o);
`default_nettype wire

// File: verification/fe_config_regs_tb.sv
// Self-checking bench for the front-end configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "fe_map.svh"
module fe_config_regs_tb;
    import fe_pkg::*;
    localparam logic [7:0] RST_V [5] = '{8'h56, 8'h10, 8'hA9, 8'h0A, 8'h00};
    localparam logic [7:0] MSK_V [5] = '{8'hFF, 8'h37, 8'hFF, 8'h3F, 8'h00};
    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    reg_req_t     req;
    logic [7:0]   rdata;
    logic         rvalid;
    cal_result_t  cal = '0;
    tx_ctrl_t     txc = '0;         // Bits: active, keyed, data bit
    power_table_t ptab;
    rx_bias_t     rx_bias;
    logic [1:0]   tx_lo;
    logic [7:0]   pa_set;
    logic [2:0]   pa_entry;
    logic         pump_en;
    logic [1:0]   pump_cfg;
    logic [3:0]   pump_code;
    logic [11:0]  pump_q8;
    logic         vco_high;
    logic [4:0]   vco_code;
    int           checked = 0;
    int           fails = 0;
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
    always #4 clk_i = ~clk_i;
    // Distinct table bytes so a wrong entry cannot match
    initial for (int n = 0; n < 8; n++) ptab[n] = 8'hC0 | 8'(n);
    fe_config_regs u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .cal_result_i(cal), .tx_ctrl_i(txc),
        .power_level_table_i(ptab), .rx_bias_o(rx_bias), .tx_lo_buffer_current_o(tx_lo),
        .pa_setting_o(pa_set), .pa_entry_o(pa_entry), .pump_cal_stage_enable_o(pump_en),
        .pump_cal_config_o(pump_cfg), .pump_current_code_o(pump_code),
        .pump_current_q8_o(pump_q8), .vco_core_high_select_o(vco_high),
        .vco_current_code_o(vco_code));
    fe_host_model u_host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_req_o(req));
    task automatic summarize;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Read one place and compare with its expected byte
    task automatic expect_reg(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        u_host.read_reg(a, d, ok);
        `CHECK("read answered", 1'b1, ok)
        `CHECK("read data", e, d)
        if (ok !== 1'b1) summarize();
    endtask
    // Bounded wait for the ramp pointer, counting the steps taken
    task automatic wait_entry(input logic [2:0] tgt, output int steps);
        logic [2:0] last;
        last  = pa_entry;
        steps = 0;
        for (int i = 0; i < 120 && pa_entry !== tgt; i++) begin
            @(negedge clk_i);
            if (pa_entry !== last) steps++;
            last = pa_entry;
        end
        `CHECK("ramp wait", tgt, pa_entry)
        if (pa_entry !== tgt) summarize();
    endtask
    task automatic test_reset;
        for (int i = 0; i < 5; i++) expect_reg(`FE_OFS_RX_BIAS + 6'(i), RST_V[i]);
        `CHECK("rx bias", 8'h56, rx_bias)
        `CHECK("pump stage", 1'b1, pump_en)
        `CHECK("core select", 1'b0, vco_high)
        `CHECK("pump scale", 12'h4C0, pump_q8)
        $display("test reset done");
    endtask
    task automatic test_masks;
        for (int i = 0; i < 5; i++) u_host.write_reg(`FE_OFS_RX_BIAS + 6'(i), 8'hFF);
        for (int i = 0; i < 5; i++) expect_reg(`FE_OFS_RX_BIAS + 6'(i), MSK_V[i]);
        `CHECK("rx bias", 8'hFF, rx_bias)
        `CHECK("tx lo current", 2'h3, tx_lo)
        `CHECK("core select", 1'b1, vco_high)
        u_host.write_reg(`FE_OFS_PUMP_CAL, 8'h80);
        u_host.write_reg(`FE_OFS_VCO_CAL, 8'h07);
        `CHECK("pump stage", 1'b0, pump_en)
        `CHECK("core select", 1'b0, vco_high)
        `CHECK("vco override", 5'h07, vco_code)
        $display("test masks done");
    endtask
    task automatic test_cal_hop;
        u_host.prep_cal(2'h2, 6'h29);
        @(negedge clk_i);
        cal = '{pump_valid: 1'b1, pump_code: 4'h6, vco_valid: 1'b1, vco_code: 5'h13};
        @(negedge clk_i);
        cal = '0;
        @(negedge clk_i);
        `CHECK("pump scale", 12'h2D4, pump_q8)
        expect_reg(`FE_OFS_PUMP_CAL, 8'hA6);
        expect_reg(`FE_OFS_VCO_CAL, 8'h13);
        u_host.restore_cal(8'hA0, 8'h21);
        u_host.restore_cal(8'hA6, 8'h13);
        `CHECK("pump result", 4'h6, pump_code)
        `CHECK("vco result", 5'h13, vco_code)
        `CHECK("pump config", 2'h2, pump_cfg)
        $display("test calibration hop done");
    endtask
    task automatic test_ramp;
        int steps;
        for (int k = 5; k < 8; k += 2) begin
            u_host.write_reg(`FE_OFS_TX_CONFIG, 8'(k));
            txc = 3'b100;
            wait_entry(3'(k), steps);
            `CHECK("ramp up steps", k, steps)
            @(negedge clk_i);
            `CHECK("power setting", ptab[k], pa_set)
            txc = 3'b000;
            wait_entry(3'h0, steps);
            `CHECK("ramp down steps", k, steps)
        end
        txc = 3'b111;
        wait_entry(3'h7, steps);
        txc = 3'b110;
        wait_entry(3'h0, steps);
        @(negedge clk_i);
        `CHECK("keyed zero setting", ptab[0], pa_set)
        txc = 3'b000;
        $display("test ramp done");
    endtask
    initial begin
        repeat (4) @(negedge clk_i);
        sys_rst_i = 1'b0;
        test_reset();
        test_masks();
        test_cal_hop();
        test_ramp();
        summarize();
    end
endmodule
`default_nettype wire

// File: verification/fe_host_model.sv
// Host side of the register port: single-byte writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "fe_map.svh"
module fe_host_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  reg_rdata_i,
    input  wire logic        reg_rvalid_i,
    output fe_pkg::reg_req_t reg_req_o
);
    import fe_pkg::*;
    initial reg_req_o = '0;
    // Turn address and data over when idle so stale values never pass for fresh ones
    task automatic release_bus;
        reg_req_o.wr    = 1'b0;
        reg_req_o.rd    = 1'b0;
        reg_req_o.addr  = ~reg_req_o.addr;
        reg_req_o.wdata = ~reg_req_o.wdata;
    endtask
    // Request held across exactly one rising edge
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        release_bus();
    endtask
    // Answer is registered at the taking edge and seen at the next negedge; waits are bounded
    task automatic read_reg(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_i);
        reg_req_o.rd   = 1'b1;
        reg_req_o.addr = a;
        @(negedge clk_i);
        release_bus();
        ok = 1'b0;
        d  = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid_i === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata_i;
            end else begin
                @(negedge clk_i);
            end
        end
    endtask
    // Configuration pair goes in before a calibration starts
    task automatic prep_cal(input logic [1:0] cfg, input logic [5:0] keep);
        write_reg(`FE_OFS_PUMP_CAL, {cfg, keep});
    endtask
    // Saved results written back in place of a fresh calibration
    task automatic restore_cal(input logic [7:0] p, input logic [7:0] v);
        write_reg(`FE_OFS_PUMP_CAL, p);
        write_reg(`FE_OFS_VCO_CAL, v);
    endtask
endmodule
`default_nettype wire
